// ===== utrc_core.sv
// Serial transmit and receive core with an Avalon-MM register slave
// Contract
// - Powered and idle, the serial output stays at the high idle level.
// - Enabled write to transmit buffer starts a frame with start, parity if configured, stop added.
// - Transmit done pulses right after the last stop bit; then the line idles unless the buffer is full.
// - Next byte is accepted once shifting starts, so frames follow without gap.
// - Transmit status bit 1 is buffer full; 1 forbids a write.
// - Transmit status bit 0 is shift busy while a frame is in progress.
// - After a write to an idle transmitter full and busy step 10, 11, then 01.
// - Reception samples the input only after power and then receive enable.
// - Falling edge starts a count of the divisor; low then confirms a start.
// - Bits shift in at baud rate; stop bit raises done and fills the buffer.
// - On overrun the receive buffer keeps its old byte.
// - Parity mismatch does not abort; error is signalled at frame end.
// - Receiver checks one stop bit only and ignores a second.
// - With merge 0, any error flag set by a frame gives an error request at its end.
// - Parity error when received parity disagrees with the configured even or odd parity.
// - Framing error when the stop bit position is not high.
// - Overrun error when a frame ends before the buffer was read.
// - Reading the error status register clears only the flags that the read returned.
// - Frame: start, 7 or 8 data, optional even, odd or zero parity, 1 or 2 stops.
// - Even parity flags odd ones count, odd flags even; zero and none never.
// - Merge 0 gives errors on the error request; merge 1 on receive done.
// - Overrun, parity and framing flags sit at error status bits 0 to 2.
`timescale 1ns/1ps
module utrc_core (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Avalon-MM slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Serial lines
    output logic serial_out_pin,
    input wire logic serial_in_pin,
    // Interrupt requests
    output logic tx_done_irq,
    output logic rx_done_irq,
    output logic rx_error_irq
);

    utrc_pkg::utrc_mode_t operation_mode_reg;
    logic [7:0] baud_divisor_reg;
    logic [7:0] tx_buffer;
    logic tx_buffer_full;
    logic [11:0] tx_shift_reg;
    logic [3:0] tx_bits_left;
    logic [8:0] tx_cnt;
    utrc_pkg::utrc_tx_state_t tx_state;
    logic [7:0] rx_shift_reg;
    logic [7:0] rx_buffer;
    logic rx_unread;
    utrc_pkg::utrc_err_t rx_error_status_reg;
    logic [3:0] rx_bits_left;
    logic [8:0] rx_cnt;
    utrc_pkg::utrc_rx_state_t rx_state;
    logic rx_prev;
    logic power_seen;
    logic bus_ack;
    logic [2:0] err_snapshot;

    logic unit_power_on;
    logic tx_run;
    logic rx_run;
    logic bus_done;
    logic reg_wr;
    logic tx_wr;
    logic rx_buf_rd;
    logic rx_err_rd;
    logic tx_shift_busy;
    logic [8:0] bit_period;
    logic tx_tick;
    logic rx_tick;
    logic rx_half;
    logic rx_level;
    logic rx_has_par;
    logic rx_frame_end;
    logic [7:0] rx_data;
    logic rx_par_bit;
    logic rx_par_chk;
    logic rx_par_bad_q;
    utrc_pkg::utrc_err_t rx_new_err;
    utrc_pkg::utrc_txframe_t tx_next_frame;
    logic [7:0] next_readdata;

    // Build the whole frame at load time so the shifter only moves ones in
    function automatic utrc_pkg::utrc_txframe_t build_frame(
        input logic [7:0] d,
        input utrc_pkg::utrc_mode_t m
    );
        utrc_pkg::utrc_txframe_t f;
        logic [7:0] dm;
        logic p;
        logic [3:0] len;
        logic [3:0] pos;
        f.bits = utrc_pkg::LINE_IDLE;
        f.bits[0] = 1'b0;
        dm = m.len8 ? d : {1'b0, d[6:0]};
        len = m.len8 ? utrc_pkg::DATA_BITS_LONG : utrc_pkg::DATA_BITS_SHORT;
        case (m.parity)
            utrc_pkg::PAR_EVEN: p = ^dm;
            utrc_pkg::PAR_ODD: p = ~^dm;
            default: p = 1'b0;
        endcase
        for (int i = 0; i < 8; i++) begin
            if (4'(i) < len) begin
                f.bits[i + 1] = dm[i];
            end
        end
        pos = len + 4'h1;
        if (m.parity != utrc_pkg::PAR_NONE) begin
            f.bits[pos] = p;
            pos = pos + 4'h1;
        end
        f.nbits = pos + (m.stop2 ? 4'h2 : 4'h1);
        build_frame = f;
    endfunction

    assign unit_power_on = operation_mode_reg.power;
    assign tx_run = unit_power_on & operation_mode_reg.tx_en;
    // Power must be seen one cycle before receive enable counts
    assign rx_run = power_seen & unit_power_on & operation_mode_reg.rx_en;
    assign rx_level = unit_power_on ? serial_in_pin : 1'b1;
    assign bit_period = {baud_divisor_reg, 1'b0};
    assign tx_tick = (tx_cnt == bit_period - 9'h001);
    assign rx_tick = (rx_cnt == bit_period - 9'h001);
    assign rx_half = (rx_cnt == {1'b0, baud_divisor_reg} - 9'h001);
    assign tx_shift_busy = (tx_state != utrc_pkg::TX_IDLE);
    assign tx_next_frame = build_frame(tx_buffer, operation_mode_reg);
    assign rx_has_par = (operation_mode_reg.parity != utrc_pkg::PAR_NONE);

    // Bus handshake: one wait cycle, then the access completes
    assign avs_waitrequest = (avs_read | avs_write) & ~bus_ack;
    assign bus_done = (avs_read | avs_write) & bus_ack;
    assign reg_wr = bus_done & avs_write & avs_byteenable[0];
    assign tx_wr = reg_wr & (avs_address == utrc_pkg::ADDR_TXBUF) & tx_run;
    assign rx_buf_rd = bus_done & avs_read & (avs_address == utrc_pkg::ADDR_RXBUF);
    assign rx_err_rd = bus_done & avs_read & (avs_address == utrc_pkg::ADDR_RXERR);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bus_ack <= 1'b0;
        end else begin
            bus_ack <= (avs_read | avs_write) & ~bus_ack;
        end
    end

    always_comb begin
        next_readdata = 8'h00;
        case (avs_address)
            utrc_pkg::ADDR_MODE: next_readdata = operation_mode_reg;
            utrc_pkg::ADDR_BAUD: next_readdata = baud_divisor_reg;
            utrc_pkg::ADDR_TXSTAT: begin
                next_readdata[utrc_pkg::TXSTAT_FULL_BIT] = tx_buffer_full;
                next_readdata[utrc_pkg::TXSTAT_BUSY_BIT] = tx_shift_busy;
            end
            utrc_pkg::ADDR_RXBUF: next_readdata = rx_buffer;
            utrc_pkg::ADDR_RXERR: next_readdata = {5'h00, rx_error_status_reg};
            default: next_readdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            avs_readdata <= 32'h0000_0000;
            err_snapshot <= 3'h0;
        end else if (avs_read & ~bus_ack) begin
            avs_readdata <= {24'h000000, next_readdata};
            err_snapshot <= rx_error_status_reg;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            operation_mode_reg <= utrc_pkg::MODE_RST;
            baud_divisor_reg <= utrc_pkg::BAUD_RST;
        end else if (reg_wr) begin
            if (avs_address == utrc_pkg::ADDR_MODE) begin
                operation_mode_reg <= avs_writedata[7:0];
            end
            if (avs_address == utrc_pkg::ADDR_BAUD) begin
                baud_divisor_reg <= avs_writedata[7:0];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            power_seen <= 1'b0;
        end else begin
            power_seen <= unit_power_on;
        end
    end

    // Transmit buffer; a write while full overwrites, which software must avoid
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_buffer <= 8'h00;
            tx_buffer_full <= 1'b0;
        end else if (!tx_run) begin
            tx_buffer_full <= 1'b0;
        end else if (tx_wr) begin
            tx_buffer <= avs_writedata[7:0];
            tx_buffer_full <= 1'b1;
        end else if (tx_state == utrc_pkg::TX_LOAD) begin
            tx_buffer_full <= 1'b0;
        end
    end

    // Transmit shifter; idle contents are all ones so the pin idles high
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_state <= utrc_pkg::TX_IDLE;
            tx_shift_reg <= utrc_pkg::LINE_IDLE;
            tx_bits_left <= 4'h0;
            tx_cnt <= 9'h000;
            tx_done_irq <= 1'b0;
        end else if (!tx_run) begin
            tx_state <= utrc_pkg::TX_IDLE;
            tx_shift_reg <= utrc_pkg::LINE_IDLE;
            tx_cnt <= 9'h000;
            tx_done_irq <= 1'b0;
        end else begin
            tx_done_irq <= 1'b0;
            case (tx_state)
                utrc_pkg::TX_IDLE: begin
                    tx_cnt <= 9'h000;
                    if (tx_buffer_full) begin
                        tx_state <= utrc_pkg::TX_LOAD;
                        tx_shift_reg <= tx_next_frame.bits;
                        tx_bits_left <= tx_next_frame.nbits;
                    end
                end
                utrc_pkg::TX_LOAD, utrc_pkg::TX_SHIFT: begin
                    tx_state <= utrc_pkg::TX_SHIFT;
                    tx_cnt <= tx_cnt + 9'h001;
                    if (tx_tick) begin
                        tx_cnt <= 9'h000;
                        tx_shift_reg <= {1'b1, tx_shift_reg[11:1]};
                        tx_bits_left <= tx_bits_left - 4'h1;
                        if (tx_bits_left == 4'h1) begin
                            tx_done_irq <= 1'b1;
                            if (tx_buffer_full) begin
                                tx_state <= utrc_pkg::TX_LOAD;
                                tx_shift_reg <= tx_next_frame.bits;
                                tx_bits_left <= tx_next_frame.nbits;
                            end else begin
                                tx_state <= utrc_pkg::TX_IDLE;
                            end
                        end
                    end
                end
                default: tx_state <= utrc_pkg::TX_IDLE;
            endcase
        end
    end

    assign serial_out_pin = tx_shift_reg[0];

    // Receiver
    assign rx_frame_end = (rx_state == utrc_pkg::RX_BITS) & rx_tick & (rx_bits_left == 4'h1);
    assign rx_data = operation_mode_reg.len8 ? rx_shift_reg : {1'b0, rx_shift_reg[7:1]};

    always_comb begin
        rx_new_err.overrun = rx_frame_end & rx_unread;
        rx_new_err.parity = rx_frame_end & rx_par_bad_q;
        rx_new_err.framing = rx_frame_end & ~rx_level;
    end

    // Parity is judged on the captured parity bit, not on a data bit
    assign rx_par_bad_q = rx_has_par & rx_par_chk;

    always_comb begin
        case (operation_mode_reg.parity)
            utrc_pkg::PAR_EVEN: rx_par_chk = ^{rx_data, rx_par_bit};
            utrc_pkg::PAR_ODD: rx_par_chk = ~^{rx_data, rx_par_bit};
            default: rx_par_chk = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_state <= utrc_pkg::RX_IDLE;
            rx_prev <= 1'b1;
            rx_cnt <= 9'h000;
            rx_bits_left <= 4'h0;
            rx_shift_reg <= 8'h00;
            rx_par_bit <= 1'b0;
        end else if (!rx_run) begin
            rx_state <= utrc_pkg::RX_IDLE;
            rx_prev <= 1'b1;
            rx_cnt <= 9'h000;
        end else begin
            rx_prev <= rx_level;
            case (rx_state)
                utrc_pkg::RX_IDLE: begin
                    rx_cnt <= 9'h000;
                    if (rx_prev & ~rx_level) begin
                        rx_state <= utrc_pkg::RX_START;
                    end
                end
                utrc_pkg::RX_START: begin
                    rx_cnt <= rx_cnt + 9'h001;
                    if (rx_half) begin
                        rx_cnt <= 9'h000;
                        rx_shift_reg <= 8'h00;
                        rx_bits_left <= (operation_mode_reg.len8 ? utrc_pkg::DATA_BITS_LONG
                            : utrc_pkg::DATA_BITS_SHORT) + {3'h0, rx_has_par} + 4'h1;
                        // A high level here was a glitch, not a start bit
                        rx_state <= rx_level ? utrc_pkg::RX_IDLE : utrc_pkg::RX_BITS;
                    end
                end
                utrc_pkg::RX_BITS: begin
                    rx_cnt <= rx_cnt + 9'h001;
                    if (rx_tick) begin
                        rx_cnt <= 9'h000;
                        rx_bits_left <= rx_bits_left - 4'h1;
                        if (rx_bits_left == 4'h1) begin
                            // Only one stop bit is checked; a second is idle line
                            rx_state <= utrc_pkg::RX_IDLE;
                        end else if (rx_has_par && rx_bits_left == 4'h2) begin
                            rx_par_bit <= rx_level;
                        end else begin
                            rx_shift_reg <= {rx_level, rx_shift_reg[7:1]};
                        end
                    end
                end
                default: rx_state <= utrc_pkg::RX_IDLE;
            endcase
        end
    end

    // Receive buffer; set of unread wins over a read in the same cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_buffer <= utrc_pkg::RXBUF_RST;
            rx_unread <= 1'b0;
        end else if (!unit_power_on) begin
            rx_buffer <= utrc_pkg::RXBUF_RST;
            rx_unread <= 1'b0;
        end else if (rx_frame_end && !rx_unread) begin
            rx_buffer <= rx_data;
            rx_unread <= 1'b1;
        end else if (rx_buf_rd) begin
            rx_unread <= 1'b0;
        end
    end

    // Only flags actually returned by the read are cleared, so none is lost
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_error_status_reg <= 3'h0;
        end else if (!unit_power_on) begin
            rx_error_status_reg <= 3'h0;
        end else begin
            rx_error_status_reg <= (rx_error_status_reg & ~(rx_err_rd ? err_snapshot : 3'h0))
                | rx_new_err;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_done_irq <= 1'b0;
            rx_error_irq <= 1'b0;
        end else begin
            rx_done_irq <= rx_frame_end & (operation_mode_reg.merge | ~(|rx_new_err));
            rx_error_irq <= rx_frame_end & ~operation_mode_reg.merge & (|rx_new_err);
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    property p_idle_high;
        unit_power_on && !tx_shift_busy |-> serial_out_pin;
    endproperty
    a_idle_high: assert property (p_idle_high) else $error("line not idle high");

    property p_tx_start;
        tx_wr && !tx_shift_busy && !tx_buffer_full |-> ##2 !serial_out_pin;
    endproperty
    a_tx_start: assert property (p_tx_start) else $error("no start bit");

    property p_status_steps;
        tx_wr && !tx_shift_busy && !tx_buffer_full && tx_run
            |=> (tx_buffer_full && !tx_shift_busy) ##1 (tx_buffer_full && tx_shift_busy)
            ##1 (!tx_buffer_full && tx_shift_busy);
    endproperty
    a_status_steps: assert property (p_status_steps) else $error("status sequence");

    property p_tx_done;
        tx_done_irq |-> $past(serial_out_pin) ##1 !tx_done_irq;
    endproperty
    a_tx_done: assert property (p_tx_done) else $error("done not after stop");

    property p_tx_chain;
        tx_done_irq && $past(tx_buffer_full) && tx_run |-> !serial_out_pin;
    endproperty
    a_tx_chain: assert property (p_tx_chain) else $error("gap between frames");

    property p_overrun_keep;
        rx_frame_end && rx_unread && unit_power_on
            |=> rx_error_status_reg.overrun && $stable(rx_buffer);
    endproperty
    a_overrun_keep: assert property (p_overrun_keep) else $error("overrun");

    property p_framing;
        rx_frame_end && !rx_level && unit_power_on |=> rx_error_status_reg.framing;
    endproperty
    a_framing: assert property (p_framing) else $error("framing flag");

    property p_err_clear;
        rx_err_rd && !rx_frame_end && !$past(rx_frame_end) && unit_power_on
            |=> rx_error_status_reg == 3'h0;
    endproperty
    a_err_clear: assert property (p_err_clear) else $error("flags not cleared");

    property p_err_irq;
        rx_frame_end && |rx_new_err |=> (rx_error_irq != operation_mode_reg.merge)
            && (rx_done_irq == operation_mode_reg.merge) ##1 !rx_error_irq && !rx_done_irq;
    endproperty
    a_err_irq: assert property (p_err_irq) else $error("error request");

    c_back_to_back: cover property (tx_done_irq && tx_buffer_full);
    c_rx_ok: cover property (rx_done_irq && !(|rx_error_status_reg));
    c_rx_err: cover property (rx_error_irq);
    c_overrun: cover property (rx_error_status_reg.overrun);

endmodule

// ===== utrc_pkg.sv
// Package for the serial transmit and receive core: map, fields, types
package utrc_pkg;

    // Register byte offsets on the Avalon-MM slave
    localparam logic [4:0] ADDR_MODE = 5'h00;
    localparam logic [4:0] ADDR_BAUD = 5'h04;
    localparam logic [4:0] ADDR_TXBUF = 5'h08;
    localparam logic [4:0] ADDR_TXSTAT = 5'h0C;
    localparam logic [4:0] ADDR_RXBUF = 5'h10;
    localparam logic [4:0] ADDR_RXERR = 5'h14;

    // Values after reset
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] BAUD_RST = 8'hFF;
    localparam logic [7:0] RXBUF_RST = 8'hFF;
    localparam logic [11:0] LINE_IDLE = 12'hFFF;

    // Field positions
    localparam int TXSTAT_BUSY_BIT = 0;
    localparam int TXSTAT_FULL_BIT = 1;
    localparam int ERR_OVR_BIT = 0;
    localparam int ERR_PAR_BIT = 1;
    localparam int ERR_FRM_BIT = 2;

    // Data lengths in bits
    localparam logic [3:0] DATA_BITS_LONG = 4'h8;
    localparam logic [3:0] DATA_BITS_SHORT = 4'h7;

    typedef enum logic [1:0] {
        PAR_NONE = 2'h0,
        PAR_ZERO = 2'h1,
        PAR_ODD = 2'h2,
        PAR_EVEN = 2'h3
    } utrc_parity_t;

    // Operation mode register, bit 7 down to bit 0
    typedef struct packed {
        logic power;
        logic tx_en;
        logic rx_en;
        utrc_parity_t parity;
        logic len8;
        logic stop2;
        logic merge;
    } utrc_mode_t;

    // Reception error flags, bit 2 down to bit 0
    typedef struct packed {
        logic framing;
        logic parity;
        logic overrun;
    } utrc_err_t;

    typedef struct packed {
        logic [3:0] nbits;
        logic [11:0] bits;
    } utrc_txframe_t;

    typedef enum logic [2:0] {
        TX_IDLE = 3'b001,
        TX_LOAD = 3'b010,
        TX_SHIFT = 3'b100
    } utrc_tx_state_t;

    typedef enum logic [2:0] {
        RX_IDLE = 3'b001,
        RX_START = 3'b010,
        RX_BITS = 3'b100
    } utrc_rx_state_t;

endpackage

// ===== utrc_remote.sv
// Remote serial node model: sends frames in and captures frames out
`timescale 1ns/1ps
module utrc_remote (
    // Clock
    input wire logic clk,
    // Serial lines
    input wire logic serial_out_pin,
    output logic serial_in_pin,
    // Capture length in bits
    input wire logic [3:0] cap_n
);
    // Bit period for divisor 8
    localparam int BITC = 16;
    logic [11:0] cur;
    logic [11:0] got[$];
    initial serial_in_pin = 1'b1;
    // LSB first, one bit per period; the line is left high after the frame
    task automatic send(input logic [11:0] b, input int n);
        for (int i = 0; i < n; i++) begin
            serial_in_pin <= b[i];
            repeat (BITC) @(posedge clk);
        end
        serial_in_pin <= 1'b1;
    endtask
    // Low pulse far shorter than half a bit
    task automatic glitch;
        serial_in_pin <= 1'b0;
        repeat (3) @(posedge clk);
        serial_in_pin <= 1'b1;
    endtask
    // Mid-bit sampling; no wait after the last bit, so a start right behind is not missed
    always begin
        @(negedge serial_out_pin);
        repeat (BITC / 2) @(posedge clk);
        cur = 12'hFFF;
        for (int i = 0; i < cap_n; i++) begin
            cur[i] = serial_out_pin;
            if (i + 1 < cap_n) repeat (BITC) @(posedge clk);
        end
        got.push_back(cur);
    end
endmodule

// ===== utrc_tb.sv
// Self-checking testbench for the serial transmit and receive core
`timescale 1ns/1ps
module testbench;
    logic clk;
    logic rst_b;
    logic [4:0] adr;
    logic [31:0] wd;
    logic [31:0] rdat;
    logic [31:0] v;
    logic rd, wr, wreq, sout, sin, txd, rxd, rxe;
    time t_done[$];
    int err_total = 0;
    int num_checks = 0;
    int n_rxd = 0;
    int n_rxe = 0;

    utrc_core dut_u (.clk(clk), .rst_b(rst_b), .avs_address(adr), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hF), .avs_readdata(rdat),
        .avs_waitrequest(wreq), .serial_out_pin(sout), .serial_in_pin(sin),
        .tx_done_irq(txd), .rx_done_irq(rxd), .rx_error_irq(rxe));
    utrc_remote remote_u (.clk(clk), .serial_out_pin(sout), .serial_in_pin(sin),
        .cap_n(4'hA));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk) begin
        if (txd === 1'b1) t_done.push_back($time);
        if (rxd === 1'b1) n_rxd++;
        if (rxe === 1'b1) n_rxe++;
    end

    // One access; a spare edge after release keeps requests apart
    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] x);
        adr <= a;
        wd <= {24'h0, x};
        wr <= w;
        rd <= !w;
        @(posedge clk);
        while (wreq !== 1'b0) @(posedge clk);
        v = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clk);
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic rchk(input logic [4:0] a, input logic [31:0] e);
        bus(1'b0, a, 8'h00);
        chk(v, e);
    endtask

    // Frame bits from bit 0 upward, padded high to 12
    function automatic logic [11:0] frm(input logic [7:0] x, input logic p, input logic s,
        input logic hp);
        return hp ? {1'b1, s, p, x, 1'b0} : {2'b11, s, x, 1'b0};
    endfunction

    task automatic rx(input logic [11:0] b, input int n, input int dd, input int de);
        int a;
        int e;
        a = n_rxd;
        e = n_rxe;
        remote_u.send(b, n);
        repeat (4) @(posedge clk);
        chk(n_rxd - a, dd);
        chk(n_rxe - e, de);
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        #200000;
        err_total++;
        report_and_stop();
    end

    initial begin
        rst_b = 1'b0;
        adr = 5'h00;
        wd = 32'h0;
        rd = 1'b0;
        wr = 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        chk({31'h0, sout}, 32'h1);
        rchk(utrc_pkg::ADDR_MODE, 32'(utrc_pkg::MODE_RST));
        rchk(utrc_pkg::ADDR_BAUD, 32'(utrc_pkg::BAUD_RST));
        rchk(utrc_pkg::ADDR_RXBUF, 32'(utrc_pkg::RXBUF_RST));
        rchk(5'h18, 32'h0);
        bus(1'b1, utrc_pkg::ADDR_TXSTAT, 8'hFF);
        rchk(utrc_pkg::ADDR_TXSTAT, 32'h0);
        bus(1'b1, utrc_pkg::ADDR_BAUD, 8'h08);
        bus(1'b1, utrc_pkg::ADDR_MODE, 8'h80);
        bus(1'b1, utrc_pkg::ADDR_MODE, 8'hC4);
        chk({31'h0, sout}, 32'h1);
        rx(frm(8'h5A, 1'b0, 1'b1, 1'b0), 10, 0, 0);
        rchk(utrc_pkg::ADDR_RXBUF, 32'hFF);
        $display("test reset and enable over");
        bus(1'b1, utrc_pkg::ADDR_TXBUF, 8'hA5);
        rchk(utrc_pkg::ADDR_TXSTAT, 32'h3);
        do bus(1'b0, utrc_pkg::ADDR_TXSTAT, 8'h00); while (v[1] !== 1'b0);
        chk(v, 32'h1);
        bus(1'b1, utrc_pkg::ADDR_TXBUF, 8'h3C);
        rchk(utrc_pkg::ADDR_TXSTAT, 32'h3);
        do bus(1'b0, utrc_pkg::ADDR_TXSTAT, 8'h00); while (v !== 32'h0);
        repeat (40) @(posedge clk);
        chk(t_done.size(), 2);
        chk(32'(t_done[1] - t_done[0]), 1280);
        chk(remote_u.got.size(), 2);
        chk(remote_u.got[0], frm(8'hA5, 1'b0, 1'b1, 1'b0));
        chk(remote_u.got[1], frm(8'h3C, 1'b0, 1'b1, 1'b0));
        $display("test transmit over");
        bus(1'b1, utrc_pkg::ADDR_MODE, 8'hFC);
        remote_u.glitch();
        repeat (20) @(posedge clk);
        rx(frm(8'h5A, 1'b0, 1'b1, 1'b1), 11, 1, 0);
        rchk(utrc_pkg::ADDR_RXERR, 32'h0);
        rchk(utrc_pkg::ADDR_RXBUF, 32'h5A);
        rx(frm(8'hC3, 1'b1, 1'b1, 1'b1), 11, 0, 1);
        rchk(utrc_pkg::ADDR_RXERR, 32'h2);
        rchk(utrc_pkg::ADDR_RXERR, 32'h0);
        rchk(utrc_pkg::ADDR_RXBUF, 32'hC3);
        rx(frm(8'h11, 1'b0, 1'b0, 1'b1), 11, 0, 1);
        rchk(utrc_pkg::ADDR_RXERR, 32'h4);
        rchk(utrc_pkg::ADDR_RXBUF, 32'h11);
        rx(frm(8'h21, 1'b0, 1'b1, 1'b1), 11, 1, 0);
        rx(frm(8'h42, 1'b0, 1'b1, 1'b1), 11, 0, 1);
        rchk(utrc_pkg::ADDR_RXERR, 32'h1);
        rchk(utrc_pkg::ADDR_RXBUF, 32'h21);
        bus(1'b1, utrc_pkg::ADDR_MODE, 8'hFD);
        rx(frm(8'hC3, 1'b1, 1'b1, 1'b1), 11, 1, 0);
        rchk(utrc_pkg::ADDR_RXERR, 32'h2);
        rchk(utrc_pkg::ADDR_RXBUF, 32'hC3);
        $display("test receive errors over");
        for (int p = 0; p < 4; p++) begin
            bus(1'b1, utrc_pkg::ADDR_MODE, 8'hE4 | 8'(p << 3));
            rx(frm(8'h01, 1'b0, 1'b1, p != 0), p == 0 ? 10 : 11, p != 3, p == 3);
            rchk(utrc_pkg::ADDR_RXERR, p == 3 ? 32'h2 : 32'h0);
            rchk(utrc_pkg::ADDR_RXBUF, 32'h1);
        end
        bus(1'b1, utrc_pkg::ADDR_MODE, 8'hE2);
        rx(12'h36C, 10, 1, 0);
        rchk(utrc_pkg::ADDR_RXBUF, 32'h36);
        $display("test parity and length over");
        report_and_stop();
    end
endmodule
